// ==== rtl/global_command_and_misc_control.sv ====
// Contract
// - Command register is write-only, volatile; bits 7, 3, 2, 1 and 0 written one launch their actions, bits 6-4 do nothing.
// - Command bit 7 performs a full software reset.
// - Command bit 3 stores nonvolatile registers to flash, about 50 ms.
// - Command bit 2 moves held DAC value to output; byte writes alone don't.
// - Bit 1: offsets to 000h, scales to 800h, clear filter, then store.
// - Bit 0: null X/Y offsets so outputs read zero, then store.
// - Ready output asserts when all seven output words are processed.
// - Ready returns inactive partway through the next cycle, 15-35 % duty.
// - Ready reasserts at each completed cycle, a continuous pulse train.
// - Shared pins priority: misc control, then alarm control, then pin control.
// - Control bit 8 holds sensor self-test active while set.
// - Bit 2 enables ready, bit 1 polarity high, bit 0 selects pin b.
// - Ready configuration bits are retained through software reset.
// - Self-test bit is cleared on reset.
`timescale 1ns/1ps
`default_nettype none
module global_command_and_misc_control
#(
	parameter longint STORE_CYCLES = cmd_ctrl_pkg::STORE_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        sample_done,
	input  wire logic [9:0]  sample_period,
	input  wire logic [11:0] x_incl_out,
	input  wire logic [11:0] y_incl_out,
	input  wire logic [11:0] x_accel_out,
	input  wire logic [11:0] y_accel_out,
	input  wire logic [1:0]  alarm_oe,
	input  wire logic [1:0]  alarm_level,
	input  wire logic [1:0]  pin_ctl_oe,
	input  wire logic [1:0]  pin_ctl_level,
	output logic      [1:0]  aux_pin_out,
	output logic      [1:0]  aux_pin_oe_n,
	output logic             soft_reset,
	output logic             sensor_check_enable,
	output logic      [11:0] dac_out,
	output logic             filter_clear,
	output logic             flash_store,
	output logic             store_busy,
	output logic      [11:0] offset_load_val [4],
	output logic      [11:0] scale_load_val,
	output logic      [3:0]  offset_load,
	output logic             scale_load
);
	logic [15:0] ctl_q, ctl_d;
	logic [11:0] dac_hold_q, dac_hold_d, dac_q, dac_d;
	logic [7:0]  cmd;
	logic        cmd_wr;
	logic        ctl_lo_wr, ctl_hi_wr, dac_lo_wr, dac_hi_wr;
	cmd_ctrl_pkg::seq_state_t st_q, st_d;
	logic [31:0] store_cnt_q, store_cnt_d;
	logic [9:0]  phase_q, phase_d;
	logic        ready_q, ready_d;
	logic [9:0]  ready_len;
	logic [1:0]  pin_level_q, pin_level_d, pin_oe_n_q, pin_oe_n_d;

	assign cmd_wr    = reg_wr && reg_addr == cmd_ctrl_pkg::GLOBAL_COMMAND_ADDR;
	assign cmd       = cmd_wr ? reg_wdata : 8'h00;
	assign ctl_lo_wr = reg_wr && reg_addr == cmd_ctrl_pkg::MISC_CONTROL_ADDR;
	assign ctl_hi_wr = reg_wr && reg_addr == cmd_ctrl_pkg::MISC_CONTROL_ADDR + 7'h01;
	assign dac_lo_wr = reg_wr && reg_addr == cmd_ctrl_pkg::AUX_DAC_ADDR;
	assign dac_hi_wr = reg_wr && reg_addr == cmd_ctrl_pkg::AUX_DAC_ADDR + 7'h01;

	// Software reset strobe goes to the device-wide reset controller
	assign soft_reset = cmd[cmd_ctrl_pkg::CMD_SW_RESET];

	// Ready configuration lives in a retained domain: only the power-on
	// reset returns it to default, never the software reset.
	always_comb
	begin
		ctl_d = ctl_q;
		if (ctl_lo_wr)
			ctl_d[7:0] = reg_wdata & cmd_ctrl_pkg::MISC_CONTROL_MASK[7:0];
		if (ctl_hi_wr)
			ctl_d[15:8] = reg_wdata & cmd_ctrl_pkg::MISC_CONTROL_MASK[15:8];
		if (soft_reset)
			ctl_d[cmd_ctrl_pkg::CTL_SELF_TEST] = 1'b0;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctl_q <= cmd_ctrl_pkg::MISC_CONTROL_RESET;
		else
			ctl_q <= ctl_d;
	end
	assign sensor_check_enable = ctl_q[cmd_ctrl_pkg::CTL_SELF_TEST];

	// DAC holding register; output moves only on the latch command or the software reset
	always_comb
	begin
		dac_hold_d = dac_hold_q;
		dac_d      = dac_q;
		if (dac_lo_wr)
			dac_hold_d[7:0] = reg_wdata;
		if (dac_hi_wr)
			dac_hold_d[11:8] = reg_wdata[3:0];
		if (cmd[cmd_ctrl_pkg::CMD_DAC_LATCH])
			dac_d = dac_hold_q;
		if (soft_reset)
		begin
			dac_hold_d = 12'h000;
			dac_d      = 12'h000;
		end
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			dac_hold_q <= 12'h000;
			dac_q      <= 12'h000;
		end
		else
		begin
			dac_hold_q <= dac_hold_d;
			dac_q      <= dac_d;
		end
	end
	assign dac_out = dac_q;

	// Calibration sequencer: restore or null, then the flash store
	always_comb
	begin
		st_d           = st_q;
		store_cnt_d    = store_cnt_q;
		offset_load    = 4'h0;
		scale_load     = 1'b0;
		filter_clear   = 1'b0;
		flash_store    = 1'b0;
		scale_load_val = cmd_ctrl_pkg::SCALE_NOMINAL;
		for (int i = 0; i < 4; i++)
			offset_load_val[i] = cmd_ctrl_pkg::OFFSET_NOMINAL;
		unique case (st_q)
			cmd_ctrl_pkg::ST_IDLE:
			begin
				// Restore wins over null when both arrive in one write
				// DAC latch and software reset act outside this sequencer, even while busy
				if (cmd[cmd_ctrl_pkg::CMD_FACTORY_RESTORE])
					st_d = cmd_ctrl_pkg::ST_RESTORE;
				else if (cmd[cmd_ctrl_pkg::CMD_NULL_OFFSETS])
					st_d = cmd_ctrl_pkg::ST_NULL;
				else if (cmd[cmd_ctrl_pkg::CMD_FLASH_STORE])
				begin
					st_d        = cmd_ctrl_pkg::ST_STORE;
					store_cnt_d = 32'(STORE_CYCLES - 1);
					flash_store = 1'b1;
				end
			end
			cmd_ctrl_pkg::ST_RESTORE:
			begin
				offset_load  = 4'hf;
				scale_load   = 1'b1;
				filter_clear = 1'b1;
				flash_store  = 1'b1;
				store_cnt_d  = 32'(STORE_CYCLES - 1);
				st_d         = cmd_ctrl_pkg::ST_STORE;
			end
			cmd_ctrl_pkg::ST_NULL:
			begin
				// Offset takes the negated output so the corrected value is zero
				offset_load_val[0] = 12'h000 - x_incl_out;
				offset_load_val[1] = 12'h000 - y_incl_out;
				offset_load_val[2] = 12'h000 - x_accel_out;
				offset_load_val[3] = 12'h000 - y_accel_out;
				offset_load        = 4'hf;
				flash_store        = 1'b1;
				store_cnt_d        = 32'(STORE_CYCLES - 1);
				st_d               = cmd_ctrl_pkg::ST_STORE;
			end
			cmd_ctrl_pkg::ST_STORE:
			begin
				// Store, restore and null commands during the store are dropped to protect the flash
				if (store_cnt_q == 32'h0)
					st_d = cmd_ctrl_pkg::ST_IDLE;
				else
					store_cnt_d = store_cnt_q - 32'h1;
			end
			default:
				st_d = cmd_ctrl_pkg::ST_IDLE;
		endcase
		if (soft_reset)
			st_d = cmd_ctrl_pkg::ST_IDLE;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q        <= cmd_ctrl_pkg::ST_IDLE;
			store_cnt_q <= 32'h0;
		end
		else
		begin
			st_q        <= st_d;
			store_cnt_q <= store_cnt_d;
		end
	end
	// Busy spans the whole store so the host can poll before its next command
	assign store_busy = st_q != cmd_ctrl_pkg::ST_IDLE;

	// Ready pulse: set at each completed sample, cleared after a quarter
	// of the sample period, giving a duty cycle inside 15-35 %.
	assign ready_len = 10'((32'(sample_period) * cmd_ctrl_pkg::READY_HIGH_PCT) / 100);
	always_comb
	begin
		ready_d = ready_q;
		phase_d = phase_q;
		if (sample_done)
		begin
			ready_d = 1'b1;
			phase_d = 10'h000;
		end
		else if (ready_q)
		begin
			phase_d = phase_q + 10'h001;
			// A length of one or less still gives a one-cycle pulse
			if (phase_q + 10'h001 >= ready_len)
				ready_d = 1'b0;
		end
		if (soft_reset)
			ready_d = 1'b0;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ready_q <= 1'b0;
			phase_q <= 10'h000;
		end
		else
		begin
			ready_q <= ready_d;
			phase_q <= phase_d;
		end
	end

	// Pin arbitration; output enables are active low. The pins are registered
	// so a change of priority between sources never glitches a shared line.
	always_comb
	begin
		pin_oe_n_d  = 2'h3;
		pin_level_d = 2'h0;
		for (int p = 0; p < 2; p++)
		begin
			if (ctl_q[cmd_ctrl_pkg::CTL_READY_EN] && int'(ctl_q[cmd_ctrl_pkg::CTL_READY_SEL]) == p)
			begin
				pin_oe_n_d[p]  = 1'b0;
				pin_level_d[p] = ready_q ~^ ctl_q[cmd_ctrl_pkg::CTL_READY_POL];
			end
			else if (alarm_oe[p])
			begin
				pin_oe_n_d[p]  = 1'b0;
				pin_level_d[p] = alarm_level[p];
			end
			else if (pin_ctl_oe[p])
			begin
				pin_oe_n_d[p]  = 1'b0;
				pin_level_d[p] = pin_ctl_level[p];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_oe_n_q  <= 2'h3;
			pin_level_q <= 2'h0;
		end
		else
		begin
			pin_oe_n_q  <= pin_oe_n_d;
			pin_level_q <= pin_level_d;
		end
	end

	assign aux_pin_out  = pin_level_q;
	assign aux_pin_oe_n = pin_oe_n_q;

	// Readback: the command register reads zero, control reads its bits
	always_comb
	begin
		reg_rdata = 8'h00;
		if (reg_rd && reg_addr == cmd_ctrl_pkg::MISC_CONTROL_ADDR)
			reg_rdata = ctl_q[7:0];
		else if (reg_rd && reg_addr == cmd_ctrl_pkg::MISC_CONTROL_ADDR + 7'h01)
			reg_rdata = ctl_q[15:8];
		else if (reg_rd && reg_addr == cmd_ctrl_pkg::AUX_DAC_ADDR)
			reg_rdata = dac_hold_q[7:0];
		else if (reg_rd && reg_addr == cmd_ctrl_pkg::AUX_DAC_ADDR + 7'h01)
			reg_rdata = {4'h0, dac_hold_q[11:8]};
	end
endmodule
`default_nettype wire

// ==== rtl/cmd_ctrl_pkg.sv ====
package cmd_ctrl_pkg;
	// Register byte offsets; the low byte of each 16-bit register is addressed
	localparam logic [6:0]  MISC_CONTROL_ADDR   = 7'h34;
	localparam logic [6:0]  GLOBAL_COMMAND_ADDR = 7'h3e;
	localparam logic [6:0]  AUX_DAC_ADDR        = 7'h30;
	// Command bit positions
	localparam int          CMD_SW_RESET        = 7;
	localparam int          CMD_FLASH_STORE     = 3;
	localparam int          CMD_DAC_LATCH       = 2;
	localparam int          CMD_FACTORY_RESTORE = 1;
	localparam int          CMD_NULL_OFFSETS    = 0;
	// Control bit positions
	localparam int          CTL_SELF_TEST       = 8;
	localparam int          CTL_READY_EN        = 2;
	localparam int          CTL_READY_POL       = 1;
	localparam int          CTL_READY_SEL       = 0;
	localparam logic [15:0] MISC_CONTROL_RESET  = 16'h0000;
	localparam logic [15:0] MISC_CONTROL_MASK   = 16'h0107;
	localparam logic [11:0] OFFSET_NOMINAL      = 12'h000;
	localparam logic [11:0] SCALE_NOMINAL       = 12'h800;
	// Flash store time and clock rate
	localparam longint      STORE_TIME_MS       = 50;
	localparam longint      CLK_HZ              = 20000000;
	localparam longint      STORE_CYCLES        = (STORE_TIME_MS * CLK_HZ) / 1000;
	// Ready pulse: high for this percentage of the sample period
	localparam int          READY_HIGH_PCT      = 25;
	typedef enum logic [3:0]
	{
		ST_IDLE    = 4'b0001,
		ST_RESTORE = 4'b0010,
		ST_NULL    = 4'b0100,
		ST_STORE   = 4'b1000
	} seq_state_t;
endpackage

// ==== sim/cmd_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmd_ctrl_props
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic [6:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        soft_reset,
	input wire logic        sensor_check_enable,
	input wire logic [11:0] dac_out,
	input wire logic        filter_clear,
	input wire logic        flash_store,
	input wire logic        store_busy,
	input wire logic [3:0]  offset_load,
	input wire logic        scale_load
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic cmd;
	assign cmd = reg_wr && reg_addr == cmd_ctrl_pkg::GLOBAL_COMMAND_ADDR;
	a_reset_strobe: assert property (cmd && reg_wdata[7] |-> soft_reset) else $error("no soft reset");
	a_strobe_cause: assert property (soft_reset |-> cmd && reg_wdata[7]) else $error("stray soft reset");
	a_reset_clears: assert property (soft_reset |=> !sensor_check_enable && dac_out == 12'h000)
		else $error("soft reset left state");
	a_dac_hold: assert property (!(cmd && reg_wdata[2]) && !soft_reset |=> $stable(dac_out))
		else $error("dac moved without latch");
	a_store_launch: assert property (cmd && reg_wdata == 8'h08 && !store_busy |-> flash_store ##1 store_busy[*8])
		else $error("store not launched");
	a_restore_loads: assert property (cmd && reg_wdata == 8'h02 && !store_busy
		|=> offset_load == 4'hf && scale_load && filter_clear && flash_store) else $error("restore incomplete");
	a_null_loads: assert property (cmd && reg_wdata == 8'h01 && !store_busy
		|=> offset_load == 4'hf && !scale_load && !filter_clear && flash_store) else $error("null incomplete");
	a_unused_quiet: assert property (cmd && reg_wdata == 8'h70 |-> !flash_store ##1 offset_load == 4'h0)
		else $error("unused bits acted");
	a_pulse_once: assert property (flash_store |=> !flash_store) else $error("store pulse too long");
	cover property (cmd && reg_wdata == 8'h02);
	cover property (soft_reset);
	cover property (offset_load == 4'hf && !scale_load);
endmodule
bind global_command_and_misc_control cmd_ctrl_props cmd_ctrl_props_i (.ref_clk(ref_clk), .rst(rst),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_reset(soft_reset),
	.sensor_check_enable(sensor_check_enable), .dac_out(dac_out), .filter_clear(filter_clear),
	.flash_store(flash_store), .store_busy(store_busy), .offset_load(offset_load), .scale_load(scale_load));
`default_nettype wire

// ==== sim/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	// Released lines show the inverse so a design that samples them idle is caught
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge ref_clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		{reg_rd, reg_addr} = {1'b1, a};
		@(posedge ref_clk);
		d = reg_rdata;
		@(negedge ref_clk);
		{reg_rd, reg_addr} = {1'b0, ~a};
	endtask
endmodule
`default_nettype wire

// ==== sim/global_command_and_misc_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module global_command_and_misc_control_test;
	logic        ref_clk, rst, reg_wr, reg_rd, sample_done, soft_reset, sensor_check_enable;
	logic        filter_clear, flash_store, store_busy, scale_load;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [9:0]  sample_period;
	logic [1:0]  alarm_oe, alarm_level, pin_ctl_oe, pin_ctl_level, aux_pin_out, aux_pin_oe_n;
	logic [11:0] dac_out, scale_load_val, outs [4], olv [4];
	logic [3:0]  offset_load;
	logic [31:0] seed = 32'h00000029;
	logic [6:0]  exp_q [$];
	int          n_mismatch = 0, n_compared = 0;
	localparam logic [6:0] CMD = cmd_ctrl_pkg::GLOBAL_COMMAND_ADDR, MSC = cmd_ctrl_pkg::MISC_CONTROL_ADDR;
	global_command_and_misc_control #(.STORE_CYCLES(20)) global_command_and_misc_control_i (.ref_clk(ref_clk),
		.rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_done(sample_done), .sample_period(sample_period), .x_incl_out(outs[0]),
		.y_incl_out(outs[1]), .x_accel_out(outs[2]), .y_accel_out(outs[3]), .alarm_oe(alarm_oe),
		.alarm_level(alarm_level), .pin_ctl_oe(pin_ctl_oe), .pin_ctl_level(pin_ctl_level), .aux_pin_out(aux_pin_out),
		.aux_pin_oe_n(aux_pin_oe_n), .soft_reset(soft_reset), .sensor_check_enable(sensor_check_enable),
		.dac_out(dac_out), .filter_clear(filter_clear), .flash_store(flash_store), .store_busy(store_busy),
		.offset_load_val(olv), .scale_load_val(scale_load_val), .offset_load(offset_load), .scale_load(scale_load));
	spi_host_model spi_host_model_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Whole sequence needs well under 1000 cycles; four times that allows slow stores
	initial
	begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	always @(posedge ref_clk)
		if (flash_store === 1'b1)
		begin
			automatic logic [6:0] note = exp_q.size() ? exp_q.pop_front() : 7'h40;
			`CHK("command effects", note, {1'b0, offset_load, scale_load, filter_clear})
			for (int i = 0; i < 4; i++)
				if (offset_load[i] === 1'b1)
					`CHK("offset value", scale_load ? cmd_ctrl_pkg::OFFSET_NOMINAL : 12'h000 - outs[i], olv[i])
			if (scale_load === 1'b1)
				`CHK("scale value", cmd_ctrl_pkg::SCALE_NOMINAL, scale_load_val)
		end
	initial
	begin
		logic [31:0] r;
		logic [7:0]  d;
		logic [6:0]  ra [4];
		logic [7:0]  cmds [3];
		logic [6:0]  notes [3];
		int          n;
		ra = '{MSC, MSC + 7'h01, CMD, 7'h20};
		cmds = '{8'h08, 8'h02, 8'h01};
		notes = '{7'h00, 7'h3f, 7'h3c};
		{rst, sample_done, sample_period, alarm_oe, alarm_level} = {2'b10, 10'h028, 2'b01, 2'b00};
		{pin_ctl_oe, pin_ctl_level} = 4'hf;
		outs = '{default: 12'h000};
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) rst = 0;
		foreach (ra[i])
		begin
			spi_host_model_i.rd(ra[i], d);
			`CHK("reset read", 8'h00, d)
		end
		r = xs();
		spi_host_model_i.wr(cmd_ctrl_pkg::AUX_DAC_ADDR, r[7:0]);
		spi_host_model_i.wr(cmd_ctrl_pkg::AUX_DAC_ADDR + 7'h01, r[15:8]);
		`CHK("dac before latch", 12'h000, dac_out)
		spi_host_model_i.wr(CMD, 8'h04);
		`CHK("dac latched", {r[11:8], r[7:0]}, dac_out)
		for (int k = 0; k < 3; k++)
		begin
			foreach (outs[i])
			begin
				r = xs();
				outs[i] = r[11:0];
			end
			exp_q.push_back(notes[k]);
			spi_host_model_i.wr(CMD, cmds[k]);
			`CHK("store busy", 1'b1, store_busy)
			n = 0;
			while (n < 100 && store_busy !== 1'b0)
			begin
				@(negedge ref_clk);
				n++;
			end
			// Bench store count is 20; restore and null spend one extra load cycle
			`CHK("store length", k ? 21 : 20, n)
		end
		spi_host_model_i.wr(CMD, 8'h70);
		spi_host_model_i.wr(MSC, 8'hff);
		spi_host_model_i.wr(MSC + 7'h01, 8'hff);
		spi_host_model_i.rd(MSC, d);
		`CHK("control low", 8'h07, d)
		spi_host_model_i.rd(MSC + 7'h01, d);
		`CHK("control high", 8'h01, d)
		`CHK("self test", 1'b1, sensor_check_enable)
		`CHK("pin drive", 4'b0000, {aux_pin_oe_n, aux_pin_out})
		for (int p = 0; p < 2; p++)
		begin
			sample_done = 1;
			@(negedge ref_clk) sample_done = 0;
			n = 0;
			repeat (39) @(negedge ref_clk) n += int'(aux_pin_out[1] === 1'b1);
			`CHK("ready width", 10, n)
		end
		spi_host_model_i.wr(CMD, 8'h80);
		`CHK("self test cleared", 1'b0, sensor_check_enable)
		`CHK("dac cleared", 12'h000, dac_out)
		spi_host_model_i.rd(MSC, d);
		`CHK("ready config kept", 8'h07, d)
		spi_host_model_i.wr(MSC, 8'h04);
		@(negedge ref_clk);
		`CHK("active low idle", 2'b01, {aux_pin_oe_n[0], aux_pin_out[0]})
		sample_done = 1;
		@(negedge ref_clk) sample_done = 0;
		@(negedge ref_clk);
		`CHK("active low ready", 1'b0, aux_pin_out[0])
		`CHK("notes left", 0, exp_q.size())
		finish_test();
	end
endmodule
`default_nettype wire
